// File: rtl/ictimer_pkg.sv
/*
  Constants, register map and enumerations for the input-capture timer.
  Assumes a 32-bit APB register bus and a 10 MHz bus clock.
*/
package ictimer_pkg;
  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH  = 3;
  localparam int COUNT_W = 16;
  localparam int ADDR_W  = 8;
  localparam int NUM_REQ = NUM_CH + 1;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_COUNT  = 8'h00;
  localparam logic [7:0] OFF_CTRL   = 8'h04;
  localparam logic [7:0] OFF_ENABLE = 8'h08;
  localparam logic [7:0] OFF_FLAGS  = 8'h0C;
  localparam logic [3:0] CAP_PAGE   = 4'h1;  // Captures at 0x10, 0x14, 0x18

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EDGE_LSB  = 0;   // Two bits per channel
  localparam int CTRL_PRESC_LSB = 8;   // Two bits
  localparam int FLAG_WRAP_BIT  = 3;
  localparam logic [5:0]  EDGE_RESET  = 6'h00;
  localparam logic [1:0]  PRESC_RESET = 2'h0;
  localparam logic [3:0]  ENABLE_RESET = 4'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_TOP   = 16'hFFFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int BUS_PERIOD_NS  = 100;
  localparam int TICK_DIV1_NS   = BUS_PERIOD_NS;            // One count per cycle
  localparam int TICK_DIV1_CYC  = TICK_DIV1_NS / BUS_PERIOD_NS;
  localparam int MUL_CYCLES     = 10;                       // Longest instruction
  localparam logic [3:0] PRESC_LIMIT_DIV1  = 4'h0;
  localparam logic [3:0] PRESC_LIMIT_DIV4  = 4'h3;
  localparam logic [3:0] PRESC_LIMIT_DIV8  = 4'h7;
  localparam logic [3:0] PRESC_LIMIT_DIV16 = 4'hF;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EDGE_OFF  = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_ANY  = 2'b11
  } edge_sel_e;

  typedef enum logic [0:0] {
    ARB_IDLE     = 1'b0,
    ARB_STACKING = 1'b1
  } arb_state_e;

  localparam logic [2:0] VEC_NONE = 3'h7;  // No source left at selection
endpackage

// File: rtl/capture_channel.sv
/*
  One capture channel: edge detection on a synchronised pin level,
  capture register and sticky capture flag.
  Assumes pin_level is already synchronised to clk.
*/
`timescale 1ns/100ps
module capture_channel
  import ictimer_pkg::*;
#(
  parameter int W = COUNT_W
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         pin_level,
  input  wire logic [1:0]   edge_sel,
  input  wire logic [W-1:0] count,
  input  wire logic         flag_clear,
  output logic [W-1:0]      cap_value,
  output logic              flag
);
  logic         last_level;
  logic         hit;
  logic [W-1:0] next_cap_value;
  logic         next_flag;

  // Edge qualification and next state
  always_comb begin
    case (edge_sel)
      EDGE_RISE: hit = pin_level & ~last_level;
      EDGE_FALL: hit = ~pin_level & last_level;
      EDGE_ANY:  hit = pin_level ^ last_level;
      default:   hit = 1'b0;
    endcase
    next_cap_value = hit ? count : cap_value;  // see R2, see R6
    next_flag      = hit | (flag & ~flag_clear); // Set wins, see R6
  end

  // State registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_level <= 1'b0;
      cap_value  <= '0;
      flag       <= 1'b0;
    end else if (ce) begin
      last_level <= pin_level;
      cap_value  <= next_cap_value;
      flag       <= next_flag;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  capture_latch_a: assert property (@(posedge clk) disable iff (!rst_n) // see R2
    ce && hit |=> cap_value == $past(count) && flag)
    else $error("capture value not latched on edge");

  rearm_latch_a: assert property (@(posedge clk) disable iff (!rst_n) // see R6
    ce && hit && flag && flag_clear |=> flag && cap_value == $past(count))
    else $error("edge during pending flag lost");

  disabled_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // see R11
    edge_sel == EDGE_OFF |=> $stable(cap_value))
    else $error("disabled channel changed capture value");
endmodule

// File: rtl/vector_arbiter.sv
/*
  Interrupt request sequencing: waits for an instruction boundary, starts
  stacking, and picks the vector only when stacking is complete.
  Request bit 0 has the highest priority. The last bit is overflow.
*/
`timescale 1ns/100ps
module vector_arbiter
  import ictimer_pkg::*;
#(
  parameter int N = NUM_REQ
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [N-1:0] request,
  input  wire logic         instr_boundary,
  input  wire logic         ccr_stacked,
  input  wire logic         stack_done,
  output logic              irq,
  output logic              stack_start,
  output logic              vector_valid,
  output logic [2:0]        vector_id
);
  arb_state_e   state;
  arb_state_e   next_state;
  logic [N-1:0] snapshot;
  logic [N-1:0] next_snapshot;
  logic         ccr_seen;
  logic         next_ccr_seen;
  logic         next_stack_start;
  logic         next_vector_valid;
  logic [2:0]   next_vector_id;
  logic [2:0]   pick;

  // Highest-priority source in the snapshot
  always_comb begin
    pick = VEC_NONE;
    for (int i = N - 1; i >= 0; i--) begin
      if (snapshot[i]) pick = 3'(i);  // see R7
    end
  end

  // Sequencing
  always_comb begin
    next_state        = state;
    next_snapshot     = snapshot;
    next_ccr_seen     = ccr_seen;
    next_stack_start  = 1'b0;
    next_vector_valid = 1'b0;
    next_vector_id    = vector_id;
    case (state)
      ARB_IDLE: begin
        if (instr_boundary && |request) begin  // see R10
          next_state       = ARB_STACKING;
          next_stack_start = 1'b1;
          next_snapshot    = request;
          next_ccr_seen    = 1'b0;
        end
      end
      ARB_STACKING: begin
        if (!ccr_seen) begin
          next_snapshot = request;  // Late captures still join, see R9
          next_ccr_seen = ccr_stacked;
        end
        if (stack_done) begin  // see R8
          next_state        = ARB_IDLE;
          next_vector_valid = 1'b1;
          next_vector_id    = pick;
        end
      end
      default: next_state = ARB_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= ARB_IDLE;
      snapshot     <= '0;
      ccr_seen     <= 1'b0;
      irq          <= 1'b0;
      stack_start  <= 1'b0;
      vector_valid <= 1'b0;
      vector_id    <= VEC_NONE;
    end else if (ce) begin
      state        <= next_state;
      snapshot     <= next_snapshot;
      ccr_seen     <= next_ccr_seen;
      irq          <= |request;
      stack_start  <= next_stack_start;
      vector_valid <= next_vector_valid;
      vector_id    <= next_vector_id;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  boundary_only_a: assert property (@(posedge clk) disable iff (!rst_n) // see R10
    $rose(stack_start) |-> $past(instr_boundary) && $past(|request))
    else $error("stacking started off an instruction boundary");

  defer_select_a: assert property (@(posedge clk) disable iff (!rst_n) // see R8
    vector_valid |-> $past(stack_done) && $past(state) == ARB_STACKING)
    else $error("vector selected before stacking finished");

  priority_pick_a: assert property (@(posedge clk) disable iff (!rst_n) // see R7
    ce && state == ARB_STACKING && stack_done && |snapshot[N-2:0]
    |=> vector_valid && vector_id != 3'(N - 1))
    else $error("overflow chosen over a pending capture");

  ccr_window_a: assert property (@(posedge clk) disable iff (!rst_n) // see R9
    ce && state == ARB_STACKING && !ccr_seen && !stack_done && |request[N-2:0]
    |=> |snapshot[N-2:0])
    else $error("capture before condition codes stacked was dropped");

  preempt_c: cover property (@(posedge clk) disable iff (!rst_n)
    state == ARB_STACKING && !ccr_seen && snapshot == {1'b1, {(N-1){1'b0}}}
    ##1 |snapshot[N-2:0]);

  overflow_vec_c: cover property (@(posedge clk) disable iff (!rst_n)
    vector_valid && vector_id == 3'(N - 1));
endmodule

// File: rtl/input_capture_overflow_timer.sv
/*
  Input-capture timer: shared 16-bit free-running counter with prescaler,
  three capture channels, wrap flag, APB register file and interrupt
  vector sequencing.
  Assumes capture pins are asynchronous and the CPU side signals
  (instruction boundary, stacking progress) are on clk.
*/
// The APB slave port and the placing of the registers were decided locally.
// Function
// R1: Three independent capture channels, each with its own edge choice.
// R2: A selected edge latches the shared counter into that channel's register.
// R3: Shared 16-bit counter sets a wrap flag on overflow.
// R4: At divide-by-one the counter advances once per bus cycle.
// R5: Captured MSB one means before wrap, zero means after wrap.
// R6: A repeat edge with flag set still latches; one clear clears both.
// R7: Overflow ranks below every capture at vector selection.
// R8: Vector choice is made only after stacking completes.
// R9: Capture recognised before condition codes stack replaces the lower source.
// R10: Interrupts start only at instruction boundaries, e.g. after a multiply.
// R11: Two-bit edge select per channel: off, rise, fall, any; fields independent.
// R12: Software clears one flag by writing one to its bit only.
`timescale 1ns/100ps
module input_capture_overflow_timer
  import ictimer_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Capture pins
  input  wire logic [NUM_CH-1:0] cap_pin,
  // CPU interrupt sequencing
  input  wire logic              instr_boundary,
  input  wire logic              ccr_stacked,
  input  wire logic              stack_done,
  output logic                   irq,
  output logic                   stack_start,
  output logic                   vector_valid,
  output logic [2:0]             vector_id
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [NUM_CH-1:0]  pin_meta;
  logic [NUM_CH-1:0]  pin_sync;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;
  logic [3:0]         presc_cnt;
  logic [3:0]         next_presc_cnt;
  logic [3:0]         presc_limit;
  logic               tick;
  logic               wrap_ev;
  logic               counter_wrap_flag;
  logic               next_wrap_flag;
  logic [5:0]         edge_sel;
  logic [5:0]         next_edge_sel;
  logic [1:0]         presc_sel;
  logic [1:0]         next_presc_sel;
  logic [3:0]         enable;
  logic [3:0]         next_enable;
  logic               commit;
  logic               wr_flags;
  logic [NUM_CH-1:0]  cap_clear;
  logic [NUM_CH-1:0]  capture_n_flag;
  logic [COUNT_W-1:0] cap_value [NUM_CH];
  logic [NUM_REQ-1:0] request;
  logic               cap_hit;
  logic [1:0]         cap_idx;
  logic [31:0]        rd_word;
  logic               rd_err;
  logic               next_pready;
  logic [31:0]        next_prdata;
  logic               next_pslverr;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two stages; only the second stage is used downstream
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (ce) begin
      pin_meta <= cap_pin;
      pin_sync <= pin_meta;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and free-running counter
  // ----------------------------------------------------------------
  // Divider limit from the prescale field
  always_comb begin
    case (presc_sel)
      2'h1:    presc_limit = PRESC_LIMIT_DIV4;
      2'h2:    presc_limit = PRESC_LIMIT_DIV8;
      2'h3:    presc_limit = PRESC_LIMIT_DIV16;
      default: presc_limit = PRESC_LIMIT_DIV1;
    endcase
  end

  // Compare with >= so that lowering the prescale mid-count cannot leave
  // the divider above its new limit and make it skip ticks
  assign tick    = (presc_cnt >= presc_limit);     // see R4
  assign wrap_ev = tick && (count == COUNT_TOP);   // see R3
  assign commit  = psel && penable && pready;
  assign wr_flags = commit && pwrite && pstrb[0] && (paddr == OFF_FLAGS);
  assign cap_clear = wr_flags ? pwdata[NUM_CH-1:0] : '0;

  // Counter, divider and wrap flag next values
  always_comb begin
    next_presc_cnt = tick ? 4'h0 : presc_cnt + 4'h1;
    next_count     = tick ? count + 16'h0001 : count;  // see R3, see R4
    // Set wins over a clear in the same cycle
    next_wrap_flag = wrap_ev | (counter_wrap_flag &
                     ~(wr_flags & pwdata[FLAG_WRAP_BIT]));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc_cnt         <= 4'h0;
      count             <= COUNT_RESET;
      counter_wrap_flag <= 1'b0;
    end else if (ce) begin
      presc_cnt         <= next_presc_cnt;
      count             <= next_count;
      counter_wrap_flag <= next_wrap_flag;
    end
  end

  // ----------------------------------------------------------------
  // Capture channels
  // ----------------------------------------------------------------
  // One instance per channel, each with its own edge field
  for (genvar k = 0; k < NUM_CH; k++) begin : g_ch
    capture_channel #(
      .W          (COUNT_W)
    ) u_ch (                                       // see R1
      .clk        (clk),
      .rst_n      (rst_n),
      .ce         (ce),
      .pin_level  (pin_sync[k]),
      .edge_sel   (edge_sel[2*k +: 2]),            // see R11
      .count      (count),                         // see R2
      .flag_clear (cap_clear[k]),                  // see R12
      .cap_value  (cap_value[k]),
      .flag       (capture_n_flag[k])
    );
  end

  // ----------------------------------------------------------------
  // Interrupt sequencing
  // ----------------------------------------------------------------
  // Captures occupy the high-priority bits, overflow the last one
  // Irq is a polling level; the arbiter works from the same request vector
  assign request = {counter_wrap_flag & enable[FLAG_WRAP_BIT],
                    capture_n_flag & enable[NUM_CH-1:0]};  // see R7

  vector_arbiter #(
    .N              (NUM_REQ)
  ) u_arb (
    .clk            (clk),
    .rst_n          (rst_n),
    .ce             (ce),
    .request        (request),
    .instr_boundary (instr_boundary),               // see R10
    .ccr_stacked    (ccr_stacked),                  // see R9
    .stack_done     (stack_done),                   // see R8
    .irq            (irq),
    .stack_start    (stack_start),
    .vector_valid   (vector_valid),
    .vector_id      (vector_id)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Control and enable fields, honouring byte strobes
  // Strobes let software change the prescale without touching edge fields
  always_comb begin
    next_edge_sel  = edge_sel;
    next_presc_sel = presc_sel;
    next_enable    = enable;
    if (commit && pwrite && paddr == OFF_CTRL) begin
      if (pstrb[0]) next_edge_sel  = pwdata[CTRL_EDGE_LSB +: 6];   // see R11
      if (pstrb[1]) next_presc_sel = pwdata[CTRL_PRESC_LSB +: 2];
    end else if (commit && pwrite && paddr == OFF_ENABLE) begin
      if (pstrb[0]) next_enable = pwdata[3:0];                     // see R3
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_sel  <= EDGE_RESET;
      presc_sel <= PRESC_RESET;
      enable    <= ENABLE_RESET;
    end else if (ce) begin
      edge_sel  <= next_edge_sel;
      presc_sel <= next_presc_sel;
      enable    <= next_enable;
    end
  end

  // ----------------------------------------------------------------
  // Read decode and APB answer
  // ----------------------------------------------------------------
  // Slot 3 of the capture page is unmapped; cap_hit keeps the index in range
  assign cap_hit = (paddr[7:4] == CAP_PAGE) && (paddr[1:0] == 2'h0) &&
                   (paddr[3:2] < 2'(NUM_CH));
  assign cap_idx = paddr[3:2];

  // Address decode of the read word
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    if (paddr == OFF_COUNT) begin
      rd_word = {16'h0000, count};
    end else if (paddr == OFF_CTRL) begin
      rd_word = {22'h000000, presc_sel, 2'h0, edge_sel};
    end else if (paddr == OFF_ENABLE) begin
      rd_word = {28'h0000000, enable};
    end else if (paddr == OFF_FLAGS) begin
      rd_word = {28'h0000000, counter_wrap_flag, capture_n_flag};  // see R5
    end else if (cap_hit) begin
      rd_word = {16'h0000, cap_value[cap_idx]};
    end else begin
      rd_err  = 1'b1;
    end
  end

  // One wait state: ready rises in the second access cycle
  // Ready never stands two cycles, so back-to-back transfers each wait once
  always_comb begin
    next_pready  = psel && penable && !pready;
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (next_pready) begin
      next_prdata  = pwrite ? 32'h0000_0000 : rd_word;
      next_pslverr = rd_err || (pwrite && (paddr == OFF_COUNT || cap_hit));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready  <= next_pready;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  counter_step_a: assert property (@(posedge clk) disable iff (!rst_n) // see R4
    ce && presc_sel == 2'h0 |=> count == $past(count) + 16'h0001)
    else $error("counter did not advance once per cycle at divide by one");

  wrap_flag_a: assert property (@(posedge clk) disable iff (!rst_n) // see R3
    ce && wrap_ev |=> counter_wrap_flag && count == COUNT_RESET)
    else $error("wrap did not set flag and restart counter");

  msb_order_a: assert property (@(posedge clk) disable iff (!rst_n) // see R5
    ce && wrap_ev |-> count[COUNT_W-1] ##1 !count[COUNT_W-1])
    else $error("counter MSB does not separate before and after wrap");

  apb_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && psel && !penable ##1 ce && psel && penable |=> pready ##1 !pready)
    else $error("APB answer not in second access cycle");

  wrap_clear_a: assert property (@(posedge clk) disable iff (!rst_n) // see R3
    ce && wr_flags && pwdata[FLAG_WRAP_BIT] && !wrap_ev |=> !counter_wrap_flag)
    else $error("wrap flag not cleared by its write-one");

  flag_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // see R12
    ce && wr_flags && !pwdata[FLAG_WRAP_BIT] && counter_wrap_flag |=> counter_wrap_flag)
    else $error("wrap flag lost on a write to other flag bits");

  field_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // see R11
    ce && !(commit && pwrite && paddr == OFF_CTRL) |=> $stable(edge_sel))
    else $error("edge select changed without a control write");

  ro_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && pready && pwrite && paddr == OFF_COUNT |-> pslverr)
    else $error("write to read-only counter not refused");

  // Scenario covers
  wrap_c: cover property (@(posedge clk) disable iff (!rst_n)
    wrap_ev && |capture_n_flag);

  clear_c: cover property (@(posedge clk) disable iff (!rst_n)
    wr_flags && |cap_clear);

  presc_c: cover property (@(posedge clk) disable iff (!rst_n)
    tick && presc_sel == 2'h1);
endmodule

// File: tb/sig_source.sv
/*
  Model of the external signal sources on the three capture pins.
  Assumes the bench calls its task from a thread synchronous to clk.
*/
`timescale 1ns/100ps
module sig_source (
  input  wire logic clk,
  output logic [2:0] cap_pin
);
  // ----------------------------------------------------------------
  // Pin driving
  // ----------------------------------------------------------------
  // Pins idle low; every change lands just after a rising edge
  initial cap_pin = 3'h0;

  // One signal may feed several pins at once
  task automatic pulse(input logic [2:0] m, input int w);
    @(posedge clk);
    cap_pin <= cap_pin | m;
    repeat (w) @(posedge clk);
    cap_pin <= cap_pin & ~m;
  endtask
endmodule

// File: tb/input_capture_overflow_timer_test.sv
/*
  Self-checking bench for the input-capture timer: APB tasks and tests.
  Assumes the sig_source model drives the capture pins.
*/
`timescale 1ns/100ps
module input_capture_overflow_timer_test;
  import ictimer_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, c0, c1;
  logic        pready, pslverr, err, irq, stack_start, vector_valid;
  logic [2:0]  cap_pin, vector_id;
  logic [2:0]  vv_id = 3'h0;
  logic [2:0]  cpu = 3'h0;  // {stack_done, ccr_stacked, instr_boundary}
  int          fail_count = 0, checks = 0, cyc = 0, ss_cnt = 0, vv_cnt = 0;

  input_capture_overflow_timer dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cap_pin(cap_pin),
    .instr_boundary(cpu[0]), .ccr_stacked(cpu[1]), .stack_done(cpu[2]),
    .irq(irq), .stack_start(stack_start), .vector_valid(vector_valid),
    .vector_id(vector_id)
  );
  sig_source src (.clk(clk), .cap_pin(cap_pin));

  always #50 clk = ~clk;

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // One APB transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      fail_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One-cycle pulse on the CPU sequencing inputs
  task automatic hit(input logic [2:0] m);
    @(posedge clk);
    cpu <= m;
    @(posedge clk);
    cpu <= 3'h0;
  endtask

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic results;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Counts sequencing pulses, keeps the last vector, cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (stack_start === 1'b1)
      ss_cnt <= ss_cnt + 1;
    if (vector_valid === 1'b1) begin
      vv_cnt <= vv_cnt + 1;
      vv_id <= vector_id;
    end
    if (cyc == 80000) begin
      fail_count++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk("flags reset", 32'h0, rd);
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b1, OFF_COUNT, 32'h1234);
    chk("count write err", 32'h1, {31'h0, err});
    apb(1'b0, OFF_COUNT, 32'h0);
    c0 = rd;
    c1 = cyc;
    apb(1'b0, OFF_COUNT, 32'h0);
    chk("count step", cyc - c1, rd - c0);
    // Divide by four, then a frozen stretch at divide by one
    apb(1'b1, OFF_CTRL, 32'h100);
    apb(1'b0, OFF_COUNT, 32'h0);
    c0 = rd;
    apb(1'b0, OFF_COUNT, 32'h0);
    chk("count div4", 32'h1, rd - c0);
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b0, OFF_COUNT, 32'h0);
    c0 = rd;
    c1 = cyc;
    ce <= 1'b0;
    repeat (10) @(posedge clk);
    ce <= 1'b1;
    apb(1'b0, OFF_COUNT, 32'h0);
    chk("count frozen", cyc - c1 - 10, rd - c0);
    $display("test registers done");
    // Ch0 rising, ch1 falling, ch2 off
    apb(1'b1, OFF_CTRL, 32'h09);
    src.pulse(3'b111, 20);
    repeat (9) @(posedge clk);
    src.pulse(3'b001, 4);
    repeat (5) @(posedge clk);
    apb(1'b0, 8'h10, 32'h0);
    c0 = rd;
    apb(1'b0, 8'h14, 32'h0);
    chk("edge gap", 32'hA, c0 - rd);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk("flags", 32'h3, rd);
    apb(1'b1, OFF_FLAGS, 32'h1);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk("flags w1c", 32'h2, rd);
    $display("test capture done");
    // Ch2 any edge; capture just before and just after the wrap
    apb(1'b1, OFF_CTRL, 32'h39);
    apb(1'b0, OFF_COUNT, 32'h0);
    repeat (16'hFF00 - rd[15:0]) @(posedge clk);
    src.pulse(3'b100, 2);
    repeat (300) @(posedge clk);
    apb(1'b0, OFF_FLAGS, 32'h0);
    chk("wrap flag", 32'hE, rd);
    apb(1'b0, 8'h18, 32'h0);
    chk("msb before", 32'h1, {31'h0, rd[15]});
    apb(1'b1, OFF_FLAGS, 32'h6);
    src.pulse(3'b100, 2);
    repeat (5) @(posedge clk);
    apb(1'b0, 8'h18, 32'h0);
    chk("msb after", 32'h0, {31'h0, rd[15]});
    $display("test wrap done");
    // Interrupt sequencing with only the wrap flag pending
    apb(1'b1, OFF_FLAGS, 32'h4);
    apb(1'b1, OFF_ENABLE, 32'hF);
    repeat (12) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    chk("no boundary", 32'h0, ss_cnt);
    hit(3'b001);
    repeat (2) @(posedge clk);
    chk("stack start", 32'h1, ss_cnt);
    src.pulse(3'b100, 1);
    repeat (6) @(posedge clk);
    hit(3'b010);
    chk("early vector", 32'h0, vv_cnt);
    hit(3'b100);
    repeat (3) @(posedge clk);
    chk("vector capture", 32'h2, {29'h0, vv_id});
    apb(1'b1, OFF_FLAGS, 32'h4);
    hit(3'b001);
    repeat (2) @(posedge clk);
    hit(3'b010);
    src.pulse(3'b001, 2);
    repeat (6) @(posedge clk);
    hit(3'b100);
    repeat (3) @(posedge clk);
    chk("vector wrap", 32'h3, {29'h0, vv_id});
    chk("vector count", 32'h2, vv_cnt);
    $display("test interrupt done");
    results();
  end
endmodule
